// ==== spi_port.sv ====
// Serial port block: register file, master clock engine, slave shifter.
// Assumes all pin inputs are synchronous to mclk_i and that the pin
// direction logic outside uses the enables on pins_o.
//
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module spi_port
  import spi_port_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      arst_n_i,
  input  wire logic      ce_i,
  input  wire reg_bus_t  bus_i,
  output logic [7:0]     rdata_o,
  input  wire logic      sleep_i,
  input  wire logic      tmr2_i,
  input  wire logic      sck_i,
  input  wire logic      sdi_i,
  input  wire logic      ss_n_i,
  output spi_pins_t      pins_o,
  output logic           irq_o,
  output logic           wake_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    master_state_t ms;
    logic [4:0]    ph;
    logic [4:0]    div_cnt;
    logic          tmr_half;
    logic          pend;
    logic          sck;
    logic          sck_in;
    logic [7:0]    tx_sr;
    logic [7:0]    shift_register;
    logic [3:0]    rx_cnt;
    logic [7:0]    rx_tx_buffer;
    logic          write_collision;
    logic          ovf;
    logic          en;
    logic          clock_idle_polarity;
    logic [3:0]    mode;
    logic          sample_phase;
    logic          cke;
    logic          bf;
    logic          irq_flag;
    logic          irq_en;
    logic [7:0]    interrupt_control;
    logic [7:0]    rdata;
  } state_t;

  localparam state_t STATE_RST = '{ms: MS_IDLE, default: '0};

  state_t s_q;
  state_t s_d;

  logic master;
  logic sel_mode;
  logic port_reset;
  logic busy;
  logic tick;
  logic lead;
  logic trail;
  logic out_edge;
  logic latch_edge;
  logic do_sample;
  logic complete;
  logic [7:0] rbyte;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_master(input logic [3:0] mode);
    is_master = (mode <= MODE_MASTER_TMR2);
  endfunction : is_master

  function automatic logic [4:0] half_last(input logic [3:0] mode);
    case (mode)
      MODE_MASTER_DIV16: half_last = HALF_DIV16_LAST;
      MODE_MASTER_DIV64: half_last = HALF_DIV64_LAST;
      default:           half_last = HALF_DIV4_LAST;
    endcase
  endfunction : half_last

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    master     = s_q.en && is_master(s_q.mode);
    sel_mode   = s_q.mode == MODE_SLAVE_SEL;
    port_reset = !s_q.en || (sel_mode && ss_n_i);
    // Busy covers a running master and a slave part way through a byte
    busy       = (s_q.ms == MS_RUN) || (s_q.rx_cnt != 4'h0);
    tick       = 1'b0;
    lead       = 1'b0;
    trail      = 1'b0;
    do_sample  = 1'b0;
    complete   = 1'b0;
    rbyte      = BYTE_RST;
    s_d.rdata  = BYTE_RST;
    s_d.sck_in = sck_i;

    // Register writes; hardware events below override, so sets win
    if (bus_i.wr) begin
      case (bus_i.addr)
        ADDR_SERIAL_DATA_BUFFER: begin
          if (busy) begin
            s_d.write_collision = 1'b1;
          end else begin
            s_d.tx_sr        = bus_i.wdata;
            s_d.rx_tx_buffer = bus_i.wdata;
            if (master) begin
              s_d.ms       = MS_RUN;
              s_d.ph       = 5'h00;
              s_d.div_cnt  = 5'h00;
              s_d.tmr_half = 1'b0;
            end
          end
        end
        ADDR_SERIAL_CONTROL: begin
          s_d.write_collision = bus_i.wdata[CTL_WRITE_COLLISION];
          s_d.ovf  = bus_i.wdata[CTL_RECEIVE_OVERFLOW];
          s_d.en   = bus_i.wdata[CTL_PORT_ENABLE];
          s_d.clock_idle_polarity  = bus_i.wdata[CTL_CLOCK_IDLE_POL];
          s_d.mode = bus_i.wdata[3:0];
        end
        ADDR_SERIAL_STATUS: begin
          s_d.sample_phase = bus_i.wdata[STA_SAMPLE_PHASE];
          s_d.cke = bus_i.wdata[STA_CLOCK_EDGE_SEL];
        end
        ADDR_PERIPHERAL_IRQ_FLAGS: begin
          s_d.irq_flag = bus_i.wdata[PIR_PORT_IRQ_FLAG];
        end
        ADDR_PERIPHERAL_IRQ_ENABLES: begin
          s_d.irq_en = bus_i.wdata[PIE_PORT_IRQ_ENABLE];
        end
        ADDR_INTERRUPT_CONTROL: begin
          s_d.interrupt_control = bus_i.wdata;
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered one cycle later
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADDR_SERIAL_DATA_BUFFER: begin
          rbyte  = s_q.rx_tx_buffer;
          s_d.bf = 1'b0;
        end
        ADDR_SERIAL_CONTROL: begin
          rbyte = {s_q.write_collision, s_q.ovf, s_q.en, s_q.clock_idle_polarity, s_q.mode};
        end
        ADDR_SERIAL_STATUS: begin
          rbyte = {s_q.sample_phase, s_q.cke, 5'h00, s_q.bf};
        end
        ADDR_PERIPHERAL_IRQ_FLAGS: begin
          rbyte = {4'h0, s_q.irq_flag, 3'h0};
        end
        ADDR_PERIPHERAL_IRQ_ENABLES: begin
          rbyte = {4'h0, s_q.irq_en, 3'h0};
        end
        ADDR_INTERRUPT_CONTROL: begin
          rbyte = s_q.interrupt_control;
        end
        default: begin
          rbyte = BYTE_RST;
        end
      endcase
      s_d.rdata = rbyte;
    end

    // Master clock engine, frozen while asleep
    case (s_q.ms)
      MS_RUN: begin
        if (!sleep_i) begin
          if (s_q.mode == MODE_MASTER_TMR2) begin
            tick = tmr2_i && s_q.tmr_half;
            if (tmr2_i) begin
              s_d.tmr_half = !s_q.tmr_half;
            end
          end else begin
            tick        = s_q.div_cnt == half_last(s_q.mode);
            s_d.div_cnt = tick ? 5'h00 : 5'(s_q.div_cnt + 5'h01);
          end
          if (tick && (s_q.ph < LAST_PHASE)) begin
            s_d.sck = !s_q.sck;
            lead    = !s_q.ph[0];
            trail   = s_q.ph[0];
            s_d.ph  = 5'(s_q.ph + 5'h01);
          end
          if ((s_q.ph == LAST_PHASE) && !s_q.pend && (s_q.rx_cnt == 4'h0)) begin
            s_d.ms = MS_IDLE;
            s_d.ph = 5'h00;
          end
        end
      end
      default: begin
        s_d.sck = s_q.clock_idle_polarity;
      end
    endcase

    // Slave edges from the sampled external clock
    if (s_q.en && !master && !port_reset) begin
      lead  = s_q.clock_idle_polarity ? (!sck_i && s_q.sck_in) : (sck_i && !s_q.sck_in);
      trail = s_q.clock_idle_polarity ? (sck_i && !s_q.sck_in) : (!sck_i && s_q.sck_in);
    end

    // Output on one edge, latch on the other
    out_edge   = s_q.cke ? trail : lead;
    latch_edge = s_q.cke ? lead : trail;
    if (s_q.pend && tick) begin
      do_sample = 1'b1;
      s_d.pend  = 1'b0;
    end
    if (latch_edge) begin
      if (master && s_q.sample_phase) begin
        s_d.pend = 1'b1;
      end else begin
        do_sample = 1'b1;
      end
    end
    // Edge select 1 has the first bit out already; 0 skips first edge
    if (out_edge && (s_q.cke || (s_q.rx_cnt != 4'h0) || s_q.pend)) begin
      s_d.tx_sr = {s_q.tx_sr[6:0], 1'b0};
    end
    if (do_sample) begin
      s_d.shift_register = {s_q.shift_register[6:0], sdi_i};
      s_d.rx_cnt         = 4'(s_q.rx_cnt + 4'h1);
      if (s_q.rx_cnt == LAST_BIT) begin
        complete     = 1'b1;
        s_d.rx_cnt   = 4'h0;
        s_d.irq_flag = 1'b1;
        s_d.bf       = 1'b1;
        if (s_q.bf && !master) begin
          s_d.ovf = 1'b1;
        end else begin
          s_d.rx_tx_buffer = {s_q.shift_register[6:0], sdi_i};
        end
      end
    end

    // Port reset by select or disable
    if (port_reset) begin
      s_d.ms      = MS_IDLE;
      s_d.ph      = 5'h00;
      s_d.pend    = 1'b0;
      s_d.rx_cnt  = 4'h0;
      s_d.div_cnt = 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= STATE_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o       = s_q.rdata;
  // Carrier driven whole; members of one variable take one driver
  assign pins_o = '{sck_o:  s_q.sck,
                    sck_oe: master,
                    sdo_o:  s_q.tx_sr[7],
                    sdo_oe: s_q.en && !(sel_mode && ss_n_i)};
  assign wake_o        = s_q.irq_en && s_q.irq_flag;
  assign irq_o         = wake_o && s_q.interrupt_control[ICN_GLOBAL_ENABLE]
                         && s_q.interrupt_control[ICN_PERIPH_ENABLE];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Bus decodes shared by several checks
  logic wr_buf;
  logic wr_ctl;
  assign wr_buf = ce_i && bus_i.wr && (bus_i.addr == ADDR_SERIAL_DATA_BUFFER);
  assign wr_ctl = ce_i && bus_i.wr && (bus_i.addr == ADDR_SERIAL_CONTROL);

  chk_read_clears_full: assert property (
    ce_i && bus_i.rd && (bus_i.addr == ADDR_SERIAL_DATA_BUFFER) && !complete
    |=> !s_q.bf)
    else $error("buffer_full not cleared by buffer read");

  chk_complete_sets_flags: assert property (
    ce_i && complete |=> s_q.bf && s_q.irq_flag)
    else $error("completed byte did not set flags");

  chk_busy_write_collides: assert property (
    wr_buf && busy |=> s_q.write_collision && ($stable(s_q.tx_sr) || $past(out_edge)))
    else $error("write while busy not flagged");

  chk_collision_sticky: assert property (
    s_q.write_collision && !wr_ctl |=> s_q.write_collision)
    else $error("write_collision cleared without software");

  chk_master_write_starts: assert property (
    wr_buf && !busy && master && !port_reset |=> s_q.ms == MS_RUN ##1 1'b1)
    else $error("master write did not start transfer");

  chk_select_floats_sdo: assert property (
    sel_mode && ss_n_i |-> !pins_o.sdo_oe)
    else $error("SDO driven while slave select high");

  chk_reset_clears_count: assert property (
    ce_i && port_reset |=> s_q.rx_cnt == 4'h0 && s_q.ms == MS_IDLE)
    else $error("port reset left bit counter nonzero");

  chk_master_no_overflow: assert property (
    ce_i && master && !s_q.ovf && !wr_ctl |=> !s_q.ovf)
    else $error("overflow set in master mode");

  chk_sleep_freezes_master: assert property (
    ce_i && sleep_i && master && !port_reset && (s_q.ms == MS_RUN)
    |=> $stable(s_q.ph) && $stable(s_q.sck) && $stable(s_q.rx_cnt))
    else $error("master transfer moved during sleep");

  chk_master_ends_idle: assert property (
    ce_i && master && (s_q.ms == MS_RUN) && !sleep_i && !port_reset
    && (s_q.ph == LAST_PHASE) && !s_q.pend && (s_q.rx_cnt == 4'h0)
    |-> s_q.sck == s_q.clock_idle_polarity ##1 s_q.ms == MS_IDLE)
    else $error("master ended with SCK away from idle");

  cov_master_byte: cover property (master && complete);
  cov_slave_byte: cover property (!master && s_q.en && complete);
  cov_slave_overflow: cover property (!master && complete && s_q.bf);
  cov_write_collision: cover property (wr_buf && busy);
  cov_late_sample: cover property (master && s_q.sample_phase && complete);

endmodule : spi_port

`default_nettype wire

// ==== spi_port_pkg.sv ====
// Constants, field layouts and carrier types for the serial port block.
// Assumes a single system clock and a plain register port with one-cycle strobes.
package spi_port_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INTERRUPT_CONTROL      = 8'h0b;
  localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAGS   = 8'h0c;
  localparam logic [7:0] ADDR_SERIAL_DATA_BUFFER     = 8'h13;
  localparam logic [7:0] ADDR_SERIAL_CONTROL         = 8'h14;
  localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] ADDR_SERIAL_STATUS          = 8'h94;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_WRITE_COLLISION  = 7;
  localparam int CTL_RECEIVE_OVERFLOW = 6;
  localparam int CTL_PORT_ENABLE      = 5;
  localparam int CTL_CLOCK_IDLE_POL   = 4;
  localparam int STA_SAMPLE_PHASE     = 7;
  localparam int STA_CLOCK_EDGE_SEL   = 6;
  localparam int STA_BUFFER_FULL      = 0;
  localparam int PIR_PORT_IRQ_FLAG    = 3;
  localparam int PIE_PORT_IRQ_ENABLE  = 3;
  localparam int ICN_GLOBAL_ENABLE    = 7;
  localparam int ICN_PERIPH_ENABLE    = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] MODE_RST = 4'h0;

  // ----------------------------------------------------------------
  // Mode codes of port_mode_select
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TMR2  = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SEL    = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSEL  = 4'h5;

  // ----------------------------------------------------------------
  // Timing counts (half bit periods in mclk cycles minus one, then half bit phases per byte and last bit index)
  // ----------------------------------------------------------------
  localparam logic [4:0] HALF_DIV4_LAST  = 5'h01;
  localparam logic [4:0] HALF_DIV16_LAST = 5'h07;
  localparam logic [4:0] HALF_DIV64_LAST = 5'h1f;
  localparam logic [4:0] LAST_PHASE      = 5'h10;
  localparam logic [3:0] LAST_BIT        = 4'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_RUN  = 2'b10
  } master_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_bus_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
  } spi_pins_t;

endpackage : spi_port_pkg

// ==== spi_peer.sv ====
// Far-side SPI party: a slave that answers the block's own clock, or a master.
// Assumes pins are sampled on mclk and that the bench calls its tasks.
`timescale 1ns/100ps
`default_nettype none

module spi_peer (
  input  wire logic mclk_i,
  input  wire logic sck_i,
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      sdi_o
);
  // --------------------------------------------------------------
  // Slave role and master role
  // --------------------------------------------------------------
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic       sck_q;

  // Idle levels at time zero
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    tx_q  = 8'h00;
    rx_q  = 8'h00;
    sck_q = 1'b0;
  end

  // Latch on the rising clock, shift out on the falling clock
  always @(posedge mclk_i) begin
    sck_q <= sck_i;
    if (sck_i && !sck_q) begin
      rx_q <= {rx_q[6:0], sdo_i};
    end
    if (!sck_i && sck_q) begin
      tx_q  <= {tx_q[6:0], 1'b0};
      sdi_o <= tx_q[6];
    end
  end

  // First bit valid before the first clock edge
  task automatic load(input logic [7:0] d);
    tx_q  <= d;
    sdi_o <= d[7];
  endtask : load

  // Master role: data set before the leading edge, sampled at the trailing edge
  task automatic run_master(input logic [7:0] d, input int nbits);
    for (int i = 0; i < nbits; i++) begin
      repeat (2) @(posedge mclk_i);
      sdi_o <= d[7-i];
      repeat (3) @(posedge mclk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rx_q  <= {rx_q[6:0], sdo_i};
      sck_o <= 1'b0;
    end
    @(posedge mclk_i);
    sdi_o <= ~sdi_o;
    repeat (8) @(posedge mclk_i);
  endtask : run_master
endmodule : spi_peer

`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the serial port: register bus, master and slave links.
// Assumes spi_port_pkg and spi_peer are compiled first.
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end

module testbench;
  import spi_port_pkg::*;
  // --------------------------------------------------------------
  // Signals, clocks and instances
  // --------------------------------------------------------------
  localparam logic [7:0] CTL = ADDR_SERIAL_CONTROL;
  localparam logic [7:0] STA = ADDR_SERIAL_STATUS;
  localparam logic [7:0] BUF = ADDR_SERIAL_DATA_BUFFER;
  localparam logic [7:0] PIR = ADDR_PERIPHERAL_IRQ_FLAGS;
  localparam logic [7:0] PIE = ADDR_PERIPHERAL_IRQ_ENABLES;
  localparam logic [7:0] ICN = ADDR_INTERRUPT_CONTROL;
  logic       mclk   = 1'b0;
  logic       arst_n = 1'b0;
  reg_bus_t   bus    = '0;
  logic       sleep  = 1'b0;
  logic       tmr2   = 1'b0;
  logic       ss_n   = 1'b1;
  logic       tgl_q  = 1'b0;
  logic [1:0] div_q  = 2'h0;
  logic [7:0] rdata;
  logic [7:0] v;
  spi_pins_t  pins;
  logic       irq;
  logic       wake;
  logic       peer_sck;
  logic       peer_sdi;
  logic       sck_w;
  logic       sdo_w;
  int         error_cnt    = 0;
  int         total_checks = 0;

  always #4 mclk = ~mclk;

  // Timer pulse every fourth cycle; undriven SDO shows a toggling pattern
  always @(posedge mclk) begin
    div_q <= div_q + 2'h1;
    tmr2  <= (div_q == 2'h3);
    tgl_q <= ~tgl_q;
  end
  assign sck_w = pins.sck_oe ? pins.sck_o : peer_sck;
  assign sdo_w = pins.sdo_oe ? pins.sdo_o : tgl_q;

  spi_port spi_port_inst (.mclk_i(mclk), .arst_n_i(arst_n), .ce_i(1'b1), .bus_i(bus),
    .rdata_o(rdata), .sleep_i(sleep), .tmr2_i(tmr2), .sck_i(sck_w), .sdi_i(peer_sdi),
    .ss_n_i(ss_n), .pins_o(pins), .irq_o(irq), .wake_o(wake));
  spi_peer peer_inst (.mclk_i(mclk), .sck_i(pins.sck_oe & pins.sck_o), .sdo_i(sdo_w),
    .sck_o(peer_sck), .sdi_o(peer_sdi));

  // --------------------------------------------------------------
  // Bus and helper tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge mclk);
    bus.wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge mclk);
    bus.rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Cycles until the completion flag shows, bounded
  task automatic wait_wake(output int n);
    n = 0;
    while (wake !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
      if (n > 3000) begin
        error_cnt++;
        $display("[FAIL] t=%0t got %h exp %h", $time, wake, 1'b1);
        complete_run();
      end
    end
  endtask : wait_wake

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    rd(CTL, v);
    `CHK(v, BYTE_RST)
    rd(STA, v);
    `CHK(v, 8'h00)
    rd(PIR, v);
    `CHK(v, 8'h00)
    rd(PIE, v);
    `CHK(v, 8'h00)
    @(posedge mclk);
    #1;
    `CHK(rdata, 8'h00)
    wr(8'h55, 8'hff);
    rd(8'h55, v);
    `CHK(v, 8'h00)
    `CHK(pins.sck_oe, 1'b0)
  endtask : t_reset

  // Lag counts extra half bits before the last sample; timer phase is free
  task automatic t_master(input logic [3:0] m, input int h, input logic [7:0] d,
                          input logic [7:0] p, input logic [7:0] st, input int lag);
    int n;
    wr(STA, st);
    wr(CTL, 8'h00);
    wr(CTL, {4'h2, m});
    peer_inst.load(p);
    wr(BUF, d);
    wait_wake(n);
    `CHK(n >= 15 * h - 3 + lag * h && n <= 15 * h + 1 + lag * h, 1'b1)
    rd(STA, v);
    `CHK(v[STA_BUFFER_FULL], 1'b1)
    rd(BUF, v);
    `CHK(v, p)
    `CHK(peer_inst.rx_q, d)
    rd(STA, v);
    `CHK(v, st)
    wr(PIR, 8'h00);
  endtask : t_master

  task automatic t_collision;
    int n;
    wr(CTL, 8'h21);
    peer_inst.load(8'h0f);
    wr(BUF, 8'hc3);
    wr(BUF, 8'hff);
    wait_wake(n);
    rd(CTL, v);
    `CHK(v, 8'ha1)
    rd(BUF, v);
    `CHK(v, 8'h0f)
    `CHK(peer_inst.rx_q, 8'hc3)
    rd(CTL, v);
    `CHK(v, 8'ha1)
    wr(CTL, 8'h21);
    wr(PIR, 8'h00);
  endtask : t_collision

  task automatic t_sleep;
    int   n;
    logic s;
    wr(CTL, 8'h22);
    peer_inst.load(8'h81);
    wr(BUF, 8'h7e);
    repeat (100) @(posedge mclk);
    sleep <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    s = pins.sck_o;
    repeat (200) @(posedge mclk);
    #1;
    `CHK(pins.sck_o, s)
    `CHK(wake, 1'b0)
    @(posedge mclk);
    sleep <= 1'b0;
    wait_wake(n);
    rd(BUF, v);
    `CHK(v, 8'h81)
    `CHK(peer_inst.rx_q, 8'h7e)
    wr(PIR, 8'h00);
  endtask : t_sleep

  task automatic t_abort;
    wr(CTL, 8'h22);
    wr(BUF, 8'h55);
    repeat (50) @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    `CHK(pins.sck_oe, 1'b0)
    `CHK(pins.sck_o, 1'b0)
    @(posedge mclk);
    arst_n <= 1'b1;
    rd(CTL, v);
    `CHK(v, 8'h00)
  endtask : t_abort

  task automatic t_slave;
    wr(PIE, 8'h08);
    wr(CTL, 8'h25);
    wr(BUF, 8'h96);
    @(posedge mclk);
    peer_inst.run_master(8'h5a, 8);
    `CHK(wake, 1'b1)
    `CHK(peer_inst.rx_q, 8'h96)
    wr(PIR, 8'h00);
    @(posedge mclk);
    sleep <= 1'b1;
    peer_inst.run_master(8'h33, 8);
    `CHK(wake, 1'b1)
    sleep <= 1'b0;
    rd(CTL, v);
    `CHK(v, 8'h65)
    rd(BUF, v);
    `CHK(v, 8'h5a)
    wr(CTL, 8'h00);
    wr(PIR, 8'h00);
  endtask : t_slave

  task automatic t_select;
    wr(CTL, 8'h24);
    `CHK(pins.sdo_oe, 1'b0)
    @(posedge mclk);
    ss_n <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK(pins.sdo_oe, 1'b1)
    @(posedge mclk);
    peer_inst.run_master(8'hff, 3);
    ss_n <= 1'b1;
    #1;
    `CHK(pins.sdo_oe, 1'b0)
    @(posedge mclk);
    ss_n <= 1'b0;
    wr(BUF, 8'h3c);
    @(posedge mclk);
    peer_inst.run_master(8'hc6, 8);
    rd(BUF, v);
    `CHK(v, 8'hc6)
    `CHK(peer_inst.rx_q, 8'h3c)
    rd(CTL, v);
    `CHK(v, 8'h24)
    ss_n <= 1'b1;
  endtask : t_select

  task automatic t_irq;
    wr(ICN, 8'hc0);
    wr(PIR, 8'h08);
    `CHK(irq, 1'b1)
    wr(ICN, 8'h40);
    `CHK(irq, 1'b0)
    wr(ICN, 8'hc0);
    wr(PIR, 8'h00);
    `CHK(irq, 1'b0)
    wr(CTL, 8'h30);
    @(posedge mclk);
    #1;
    `CHK(pins.sck_o, 1'b1)
    wr(CTL, 8'h00);
  endtask : t_irq

  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    wr(PIE, 8'h08);
    wr(STA, 8'h40);
    t_master(MODE_MASTER_DIV4, 2, 8'ha5, 8'h3c, 8'h40, 0);
    t_master(MODE_MASTER_DIV16, 8, 8'h5a, 8'hc3, 8'h40, 0);
    t_master(MODE_MASTER_DIV64, 32, 8'h01, 8'h80, 8'h40, 0);
    t_master(MODE_MASTER_TMR2, 8, 8'hfe, 8'h7f, 8'h40, 0);
    t_master(MODE_MASTER_DIV16, 8, 8'h69, 8'h96, 8'hc0, 1);
    t_master(MODE_MASTER_DIV4, 2, 8'h2d, 8'hd2, 8'h00, 1);
    wr(STA, 8'h40);
    t_collision();
    t_sleep();
    t_abort();
    t_slave();
    t_select();
    t_irq();
    complete_run();
  end
endmodule : testbench

`default_nettype wire
